// >>> verilog/dprc_pkg.sv
// shared constants and state layout for the reference-loss and ratio controller
package dprc_pkg;

  // lco tick divider: 25 MHz pclk scaled by 147/250 gives 14.7 MHz
  localparam int unsigned PCLK_KHZ = 25000;
  localparam int unsigned LCO_KHZ = 14700;
  localparam logic [8:0] LCO_NUM = 9'h093;
  localparam logic [8:0] LCO_DEN = 9'h0fa;

  // timeouts in lco cycles
  localparam int unsigned T_SKIP_MS = 20;
  localparam int unsigned SKIP_TIMEOUT_LCO = T_SKIP_MS * LCO_KHZ;
  localparam int unsigned LONG_TIMEOUT_LCO = 8388608;
  // acquisition time in reference periods
  localparam int unsigned LOCK_EDGES_DEF = 200;

  localparam int unsigned PER_W = 24;
  localparam int unsigned GAP_W = 24;
  localparam int unsigned EFF_W = 40;

  // apb offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_EFF_LO = 8'h08;
  localparam logic [7:0] OFF_EFF_HI = 8'h0c;
  localparam logic [3:0] OFF_RATIO_HI = 4'h1;

  // cfg field positions
  localparam int unsigned CFG_SKIP = 0;
  localparam int unsigned CFG_OUNL = 1;
  localparam int unsigned CFG_FMT = 2;
  localparam int unsigned CFG_AUTO = 3;
  localparam int unsigned CFG_BW_LSB = 4;
  localparam int unsigned CFG_RSS_LSB = 8;
  localparam int unsigned CFG_MPF_LSB = 12;

  localparam logic [2:0] MPF_SCALE = 3'h3;
  localparam logic [2:0] MPF_AUTO = 3'h4;
  localparam logic [2:0] BW_WIDE = 3'h7;

  // fs range thresholds in lco cycles per reference period
  localparam logic [GAP_W-1:0] FS_HI_LIM = 24'h0000e0;
  localparam logic [GAP_W-1:0] FS_LO_LIM = 24'h000060;

  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_LOCK = 2'b01,
    ST_LOST = 2'b10
  } dprc_state_t;

  typedef struct packed {
    dprc_state_t st;
    logic [8:0] acc;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] last_per;
    logic have_per;
    logic [GAP_W-1:0] gap;
    logic [7:0] lock_cnt;
    logic skip_hold;
    logic [1:0] fs;
    logic ref_prev;
    logic skip_en;
    logic out_unl;
    logic fmt;
    logic auto_en;
    logic [2:0] bw_sel;
    logic [1:0] rss;
    logic [2:0] mpf;
    logic [EFF_W-1:0] eff;
    logic [2:0] bw;
    logic out_run;
    logic [31:0] prdata;
    logic pslverr;
  } dprc_regs_t;

  // reset starts in acquisition, so the loop starts wide as well
  localparam dprc_regs_t DPRC_RST = '{st: ST_ACQ, bw: BW_WIDE, default: '0};

endpackage : dprc_pkg

// >>> verilog/dprc_ratio_otp.sv
// write-once store of the four user ratio words with registered read port
`timescale 1ns/100ps
`default_nettype none
module dprc_ratio_otp #(
  parameter int unsigned W = 32,
  parameter int unsigned N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [$clog2(N)-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [$clog2(N)-1:0] rd_idx,
  output logic [W-1:0] rd_data,
  output logic [N-1:0] programmed
);
  typedef struct packed {
    logic [N-1:0][W-1:0] mem;
    logic [N-1:0] prog;
    logic [W-1:0] rd;
  } dprc_otp_t;

  dprc_otp_t q;
  dprc_otp_t d;

  always_comb begin
    d = q;
    if (wr_en && !q.prog[wr_idx]) begin
      d.mem[wr_idx] = wr_data;
      d.prog[wr_idx] = 1'b1;
    end
    d.rd = q.mem[rd_idx];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
  assign programmed = q.prog;

  otp_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.prog[wr_idx] |=> $stable(q.mem)) else $error("programmed ratio word changed");

endmodule : dprc_ratio_otp
`default_nettype wire

// >>> verilog/dprc_ctrl.sv
// reference loss, lock sequencing, loop bandwidth and effective ratio control
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dprc_ctrl
  import dprc_pkg::*;
#(
  parameter int unsigned LONG_TO_LCO = LONG_TIMEOUT_LCO,
  parameter int unsigned SKIP_TO_LCO = SKIP_TIMEOUT_LCO,
  parameter int unsigned LOCK_EDGES = LOCK_EDGES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  input wire logic [1:0] mode_sel,
  input wire logic modifier_pin,
  output logic pll_locked,
  output logic clk_out_run,
  output logic [2:0] loop_bw,
  output logic [EFF_W-1:0] effective_ratio
);
  localparam logic [GAP_W-1:0] LONG_LIM = GAP_W'(LONG_TO_LCO - 1);
  localparam logic [GAP_W-1:0] SKIP_LIM = GAP_W'(SKIP_TO_LCO);
  localparam logic [7:0] LOCK_LIM = 8'(LOCK_EDGES - 1);

  dprc_regs_t q;
  dprc_regs_t d;

  logic [8:0] acc_sum;
  logic lco_tick;
  logic ref_edge;
  logic [PER_W-1:0] per_diff;
  logic mismatch;
  logic missing;
  logic locked;
  logic setup;
  logic wr_acc;
  logic ratio_hit;
  logic otp_wr;
  logic [31:0] user_ratio;
  logic [3:0] otp_prog;
  logic [EFF_W-1:0] norm;
  logic man_act;
  logic auto_act;
  logic [2:0] man_sh;
  logic [2:0] auto_sh;
  logic [3:0] tot_sh;
  logic [31:0] rd_mux;
  logic rd_err;

  assign locked = q.st == ST_LOCK;
  assign ref_edge = ref_clk_in && !q.ref_prev;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign ratio_hit = paddr[7:4] == OFF_RATIO_HI && paddr[1:0] == 2'b00;
  assign otp_wr = wr_acc && ratio_hit;

  // mode pins address the ratio store
  dprc_ratio_otp #(
    .W(32),
    .N(4)
  ) u_otp (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(otp_wr),
    .wr_idx(paddr[3:2]),
    .wr_data(pwdata),
    .rd_idx(mode_sel),
    .rd_data(user_ratio),
    .programmed(otp_prog)
  );

  always_comb begin
    per_diff = (q.per > q.last_per) ? q.per - q.last_per : q.last_per - q.per;
    // period change beyond 1/8 counts as frequency change
    mismatch = !q.have_per || (per_diff > (q.last_per >> 3));
    missing = q.have_per && ({1'b0, q.per} > {q.last_per, 1'b0});
    norm = q.fmt ? {user_ratio, 8'h00} : {8'h00, user_ratio};
    // manual scale gated by pin and its function
    man_act = modifier_pin && q.mpf == MPF_SCALE;
    auto_act = q.auto_en || (modifier_pin && q.mpf == MPF_AUTO);
    // manual shift of 1..4 bits, automatic shift of 0..2 bits, zero when inactive
    man_sh = man_act ? {1'b0, q.rss} + 3'h1 : 3'h0;
    auto_sh = auto_act ? {1'b0, q.fs} : 3'h0;
    tot_sh = {1'b0, man_sh} + {1'b0, auto_sh};
  end

  always_comb begin
    rd_err = 1'b0;
    case (paddr)
      OFF_CFG: begin
        rd_mux = {17'h0, q.mpf, 2'h0, q.rss, 1'b0, q.bw_sel,
                  q.auto_en, q.fmt, q.out_unl, q.skip_en};
      end
      OFF_STAT: begin
        rd_mux = {12'h0, otp_prog, 5'h0, q.bw, 1'b0, q.fs,
                  q.skip_hold, q.out_run, locked, q.st};
      end
      OFF_EFF_LO: begin
        rd_mux = q.eff[31:0];
      end
      OFF_EFF_HI: begin
        rd_mux = {24'h0, q.eff[EFF_W-1:32]};
      end
      default: begin
        rd_mux = 32'h0;
        rd_err = !ratio_hit;
      end
    endcase
  end

  always_comb begin
    d = q;
    acc_sum = q.acc + LCO_NUM;
    lco_tick = acc_sum >= LCO_DEN;
    d.acc = lco_tick ? acc_sum - LCO_DEN : acc_sum;
    d.ref_prev = ref_clk_in;
    if (q.per != '1) begin
      d.per = q.per + 1'b1;
    end
    // count lco cycles since the last edge
    if (lco_tick && q.gap != '1) begin
      d.gap = q.gap + 1'b1;
    end
    if (ref_edge) begin
      d.gap = '0;
      d.per = PER_W'(1);
      d.last_per = q.per;
      d.have_per = 1'b1;
      if (!missing) begin
        d.fs = (q.gap > FS_HI_LIM) ? 2'h0 : (q.gap >= FS_LO_LIM) ? 2'h1 : 2'h2;
      end
      case (q.st)
        ST_ACQ: begin
          // stay unlocked for the acquisition time
          if (mismatch) begin
            d.lock_cnt = '0;
          end else if (q.lock_cnt == LOCK_LIM) begin
            d.st = ST_LOCK;
            d.skip_hold = 1'b0;
          end else begin
            d.lock_cnt = q.lock_cnt + 1'b1;
          end
        end
        ST_LOCK: begin
          if (mismatch) begin
            d.st = ST_ACQ;
            d.lock_cnt = '0;
            // short gap with skipping keeps output
            d.skip_hold = missing && q.skip_en && q.gap < SKIP_LIM;
          end
        end
        ST_LOST: begin
          d.st = ST_ACQ;
          d.lock_cnt = '0;
          d.skip_hold = 1'b0;
        end
        default: begin
          d.st = ST_ACQ;
        end
      endcase
    end else if (lco_tick && q.gap == LONG_LIM && q.st != ST_LOST) begin
      d.st = ST_LOST;
      d.have_per = 1'b0;
      d.skip_hold = 1'b0;
    end
    if (wr_acc && paddr == OFF_CFG) begin
      d.skip_en = pwdata[CFG_SKIP];
      d.out_unl = pwdata[CFG_OUNL];
      d.fmt = pwdata[CFG_FMT];
      d.auto_en = pwdata[CFG_AUTO];
      d.bw_sel = pwdata[CFG_BW_LSB+:3];
      d.rss = pwdata[CFG_RSS_LSB+:2];
      d.mpf = pwdata[CFG_MPF_LSB+:3];
    end
    d.eff = norm >> tot_sh;
    d.bw = (d.st == ST_LOCK) ? d.bw_sel : BW_WIDE;
    // static low while unlocked unless allowed
    d.out_run = d.st == ST_LOCK || d.out_unl || d.skip_hold;
    if (setup) begin
      d.prdata = pwrite ? 32'h0 : rd_mux;
      d.pslverr = rd_err || (pwrite && ratio_hit && otp_prog[paddr[3:2]]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= DPRC_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = q.pslverr && psel && penable;
  assign pll_locked = locked;
  assign clk_out_run = q.out_run;
  assign loop_bw = q.bw;
  assign effective_ratio = q.eff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence lost_then_edge;
    q.st == ST_LOST ##0 ref_edge;
  endsequence

  lock_bw_a: assert property (locked && $stable(q.bw_sel) |=> !locked || loop_bw == q.bw_sel)
    else $error("locked loop not at selected bandwidth");
  acq_bw_a: assert property (!locked |-> loop_bw == BW_WIDE)
    else $error("acquiring loop not wide");
  out_low_a: assert property (!locked && !q.out_unl && !q.skip_hold |-> !clk_out_run)
    else $error("clock output running while unlocked");
  skip_run_a: assert property (q.skip_hold |-> clk_out_run)
    else $error("output stopped during skip hold");
  long_lost_a: assert property (q.st != ST_LOST && q.gap == LONG_LIM && lco_tick && !ref_edge
    |=> q.st == ST_LOST && !clk_out_run == !q.out_unl)
    else $error("long timeout did not declare unlock");
  lost_ret_a: assert property (lost_then_edge |=> q.st == ST_ACQ ##1 !locked)
    else $error("return after loss did not start acquisition");
  glitch_a: assert property (locked && ref_edge && mismatch && !missing |=> !locked && !q.skip_hold)
    else $error("glitch did not drop lock");
  skip_off_a: assert property (locked && ref_edge && missing && !q.skip_en |=> !q.skip_hold)
    else $error("skip hold with skipping disabled");
  scale_one_a: assert property (!man_act && !auto_act |=> effective_ratio == $past(norm))
    else $error("effective ratio scaled with no modifier");

endmodule : dprc_ctrl
`default_nettype wire

// >>> sim/dprc_ref_src.sv
// reference clock source model with stop and period control
`timescale 1ns/100ps
`default_nettype none
module dprc_ref_src (
  input wire logic pclk,
  input wire logic run,
  input wire logic [15:0] period,
  output logic ref_clk
);
  logic [15:0] cnt_q;
  always_ff @(posedge pclk) begin
    if (!run || cnt_q >= period - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign ref_clk = run && (cnt_q < (period >> 1));
endmodule : dprc_ref_src
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the reference-loss and ratio controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dprc_pkg::*;
  typedef struct {logic [1:0] ms; logic fmt; logic [2:0] mpf; logic [1:0] rss; logic pin;
    logic [EFF_W-1:0] eff;} dprc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ref_clk, run = 1'b0, pin = 1'b0, pll_locked, clk_out_run;
  logic [15:0] period = 16'h0140;
  logic [1:0] mode_sel = 2'h0;
  logic [2:0] loop_bw;
  logic [EFF_W-1:0] effective_ratio;
  int miscompares = 0, comparisons = 0;
  logic [31:0] words [4] = '{32'h0010_0000, 32'h0030_0000, 32'h0000_1800, 32'habc0_0001};
  dprc_row_t rows [8] = '{
    '{2'h0, 1'b0, 3'h0, 2'h0, 1'b0, 40'h0000100000},
    '{2'h1, 1'b1, 3'h0, 2'h0, 1'b0, 40'h0030000000},
    '{2'h2, 1'b0, 3'h3, 2'h0, 1'b1, 40'h0000000c00},
    '{2'h3, 1'b0, 3'h3, 2'h3, 1'b1, 40'h000abc0000},
    '{2'h3, 1'b1, 3'h3, 2'h1, 1'b1, 40'h2af0000040},
    '{2'h0, 1'b0, 3'h2, 2'h0, 1'b1, 40'h0000100000},
    '{2'h1, 1'b0, 3'h3, 2'h2, 1'b0, 40'h0000300000},
    '{2'h2, 1'b1, 3'h3, 2'h2, 1'b1, 40'h0000030000}};
  always #20 pclk = ~pclk;
  dprc_ctrl #(.LONG_TO_LCO(4000), .SKIP_TO_LCO(1000), .LOCK_EDGES(4)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk_in(ref_clk), .mode_sel(mode_sel), .modifier_pin(pin),
    .pll_locked(pll_locked), .clk_out_run(clk_out_run), .loop_bw(loop_bw),
    .effective_ratio(effective_ratio));
  dprc_ref_src src (.pclk(pclk), .run(run), .period(period), .ref_clk(ref_clk));
  task automatic chk(input string name, input logic [EFF_W-1:0] got,
                     input logic [EFF_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cfg(input logic sk, input logic ou, input logic f, input logic [1:0] rs,
                     input logic [2:0] mp);
    apb(1'b1, OFF_CFG, {17'h0, mp, 2'h0, rs, 1'b0, 3'h3, 1'b0, f, ou, sk});
  endtask : cfg
  task automatic wait_lock(input logic v, input int max);
    int n;
    n = 0;
    while (pll_locked !== v && n < max) begin
      @(posedge pclk);
      n++;
    end
    chk("pll_locked", {39'h0, pll_locked}, {39'h0, v});
  endtask : wait_lock
  task automatic settled(input logic [EFF_W-1:0] r);
    chk("clk_out_run", {39'h0, clk_out_run}, r);
    chk("loop_bw", {37'h0, loop_bw}, 40'h3);
  endtask : settled
  task automatic gap(input int len, input logic drop);
    int drops;
    drops = 0;
    @(posedge ref_clk);
    @(posedge pclk);
    run <= 1'b0;
    repeat (len) @(posedge pclk);
    chk("run_in_gap", {39'h0, clk_out_run}, 40'h1);
    run <= 1'b1;
    if (drop) begin
      wait_lock(1'b0, 400);
      chk("run_reacq", {39'h0, clk_out_run}, 40'h0);
      chk("bw_acq", {37'h0, loop_bw}, {37'h0, BW_WIDE});
    end else begin
      repeat (2500) begin
        @(posedge pclk);
        if (clk_out_run !== 1'b1) drops++;
      end
      chk("drops", 40'(drops), 40'h0);
    end
    wait_lock(1'b1, 3000);
    settled(40'h1);
  endtask : gap
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge pclk);
    chk("rst_lock", {39'h0, pll_locked}, 40'h0);
    chk("rst_run", {39'h0, clk_out_run}, 40'h0);
    chk("rst_eff", effective_ratio, 40'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) apb(1'b1, {OFF_RATIO_HI, 2'(i), 2'h0}, words[i]);
    apb(1'b1, 8'h10, 32'h0);
    chk("rewrite_err", {39'h0, err}, 40'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", {39'h0, err}, 40'h1);
    foreach (rows[i]) begin
      cfg(1'b0, 1'b0, rows[i].fmt, rows[i].rss, rows[i].mpf);
      mode_sel <= rows[i].ms;
      pin <= rows[i].pin;
      repeat (3) @(posedge pclk);
      chk("effective_ratio", effective_ratio, rows[i].eff);
    end
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg_rd", {8'h0, rd}, 40'h0000003234);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stored", {36'h0, rd[19:16]}, 40'hf);
    cfg(1'b0, 1'b0, 1'b0, 2'h0, 3'h0);
    run <= 1'b1;
    wait_lock(1'b1, 3000);
    settled(40'h1);
    // automatic scale by pin: 188 lco cycles per period halves the ratio
    cfg(1'b0, 1'b0, 1'b0, 2'h1, 3'h4);
    repeat (3) @(posedge pclk);
    chk("auto_scale", effective_ratio, 40'h0000000c00);
    gap(1000, 1'b1);
    cfg(1'b1, 1'b0, 1'b0, 2'h0, 3'h0);
    gap(1000, 1'b0);
    gap(3000, 1'b1);
    cfg(1'b0, 1'b0, 1'b0, 2'h0, 3'h0);
    @(posedge ref_clk);
    @(posedge pclk);
    run <= 1'b0;
    repeat (6000) @(posedge pclk);
    chk("long_hold", {39'h0, pll_locked}, 40'h1);
    repeat (1600) @(posedge pclk);
    chk("long_lost", {39'h0, pll_locked}, 40'h0);
    chk("lost_run", {39'h0, clk_out_run}, 40'h0);
    run <= 1'b1;
    repeat (100) @(posedge pclk);
    chk("late_acq", {39'h0, pll_locked}, 40'h0);
    wait_lock(1'b1, 3000);
    settled(40'h1);
    cfg(1'b0, 1'b1, 1'b0, 2'h0, 3'h0);
    @(posedge ref_clk);
    @(posedge pclk);
    period <= 16'h00c8;
    wait_lock(1'b0, 400);
    chk("unl_run", {39'h0, clk_out_run}, 40'h1);
    wait_lock(1'b1, 3000);
    // reset in mid-run with the reference still toggling
    presetn <= 1'b0;
    @(posedge pclk);
    chk("mid_rst_lock", {39'h0, pll_locked}, 40'h0);
    chk("mid_rst_bw", {37'h0, loop_bw}, {37'h0, BW_WIDE});
    chk("mid_rst_eff", effective_ratio, 40'h0);
    presetn <= 1'b1;
    wait_lock(1'b1, 3000);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
